// *** logic/switchgear_object_control.sv ***
// Control and supervision of one switchgear object
//
// Chosen here: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
module switchgear_object_control
   import switchgear_pkg::*;
#(
   parameter int TICK_CYCLES = STEP_CYCLES,
   parameter int CNT_W = 32
)(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic ce,
   input wire logic [3:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   input wire field_type field_in,
   input wire req_type local_req,
   input wire req_type remote_req,
   input wire req_type app_req,
   input wire req_type panel_req,
   input wire logic [1:0] panel_level,
   input wire req_type interlock,
   input wire logic trip_done,
   input wire logic reclose_expected,
   output logic open_cmd,
   output logic close_cmd,
   output logic final_trip,
   output logic ctrl_error
);

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   typedef enum logic [1:0] {ST_IDLE, ST_OPEN, ST_CLOSE} state_type;
   state_type st_r;         // Control sequencer
   logic [31:0] pre_r;      // Step prescaler
   ctrl_type ctrl_r;        // Mode and source settings
   logic [15:0] trav_r;     // Traverse time in steps
   logic [15:0] cpul_r;     // Close pulse limit
   logic [15:0] opul_r;     // Open pulse limit
   logic [15:0] tout_r;     // Termination timeout
   logic [15:0] ftl_r;      // Final trip length
   logic [15:0] trav_cnt_r; // Time in no-end position
   logic [15:0] pul_cnt_r;  // Command pulse age
   logic [15:0] tout_cnt_r; // Operation age
   logic [15:0] ft_cnt_r;   // Final trip age
   logic [CNT_W-1:0] ofail_r;
   logic [CNT_W-1:0] cfail_r;
   logic clear_r;           // Clear action in progress
   pos_type brk_r;          // Reported breaker position
   pos_type cart_r;         // Reported cart position
   logic open_cmd_r;
   logic close_cmd_r;
   logic ft_r;
   logic err_r;
   logic [31:0] rdata_r;

   // ----------------------------------------
   // Decoding
   // ----------------------------------------
   wire tick = ce && (pre_r == 32'(TICK_CYCLES - 1));
   wire wr_en = ce && wr;
   wire wr_ctrl = wr_en && (addr == ADR_CTRL);
   wire wr_clear = wr_en && (addr == ADR_CLEAR);
   wire ctrl_type wctrl = ctrl_type'(wdata[10:0]);
   wire obj_kind_type kind = ctrl_r.kind;
   wire is_brk = (kind == KIND_WD) || (kind == KIND_CB); // R03 R04
   wire can_cmd = (kind != KIND_EARTH);                 // R05
   // Status inputs map directly onto the position codes
   wire pos_type raw_brk = pos_type'({field_in.closed_st,
                                      field_in.open_st}); // R06
   wire pos_type raw_cart = pos_type'({field_in.cart_in,
                                       field_in.cart_out}); // R07
   wire brk_end = (raw_brk == POS_OPEN) || (raw_brk == POS_CLOSED);
   // Request sources: local, remote and app each enabled by its own select bit, panel by access level
   wire panel_ok = (panel_level >= ctrl_r.level);       // R18
   wire want_open = (ctrl_r.src_en[0] && local_req.open_req) ||
                    (ctrl_r.src_en[1] && remote_req.open_req) ||
                    (ctrl_r.src_en[2] && app_req.open_req) ||
                    (panel_ok && panel_req.open_req);   // R19
   wire want_close = (ctrl_r.src_en[0] && local_req.close_req) ||
                     (ctrl_r.src_en[1] && remote_req.close_req) ||
                     (ctrl_r.src_en[2] && app_req.close_req) ||
                     (panel_ok && panel_req.close_req); // R19
   // Close permissives apply to breaker kinds only
   wire sync_ok = !ctrl_r.sync_en || field_in.sync_ok;  // R21
   wire ready_ok = (ctrl_r.rdy == RDY_HIGH) ? field_in.ready :
                   (ctrl_r.rdy == RDY_LOW) ? !field_in.ready :
                   1'b1;                                // R22
   wire open_ok = can_cmd && !(is_brk && interlock.open_req);
   wire close_ok = can_cmd && (!is_brk || (sync_ok && ready_ok &&
                   !interlock.close_req));              // R03 R04
   // Open wins when both requests arrive together
   wire idle = (st_r == ST_IDLE);
   wire start_o = idle && want_open && open_ok;
   wire start_c = idle && !want_open && want_close && close_ok;
   wire refuse_o = idle && want_open && !open_ok;
   wire refuse_c = idle && !want_open && want_close && !close_ok;
   wire busy = !idle;
   wire reached = (st_r == ST_OPEN) ? (raw_brk == POS_OPEN) :
                  (raw_brk == POS_CLOSED);
   wire [15:0] pul_lim = (st_r == ST_OPEN) ? opul_r : cpul_r;
   wire pul_end = tick && ((pul_cnt_r + 16'd1) >= pul_lim);
   wire expire = busy && !reached && tick &&
                 ((tout_cnt_r + 16'd1) >= tout_r);      // R15
   wire fail_o = refuse_o || (expire && st_r == ST_OPEN);  // R23
   wire fail_c = refuse_c || (expire && st_r == ST_CLOSE); // R23
   wire ft_start = trip_done && !reclose_expected;      // R17
   wire ft_end = (ftl_r == 16'h0000) ?
                 (wr_ctrl && wctrl.ft_release) :
                 (tick && ((ft_cnt_r + 16'd1) >= ftl_r)); // R16
   wire [CNT_W-1:0] ofail_nxt =
      (clear_r ? '0 : ofail_r) + CNT_W'(fail_o);        // R01 R02
   wire [CNT_W-1:0] cfail_nxt =
      (clear_r ? '0 : cfail_r) + CNT_W'(fail_c);        // R01 R02
   wire status_type stat = '{sync_ok: sync_ok, ready_ok: ready_ok,
      open_allowed: open_ok, close_allowed: close_ok, busy: busy,
      final_trip: ft_r, close_cmd: close_cmd_r, open_cmd: open_cmd_r,
      cart_used: kind == KIND_WD, cart: cart_r, brk: brk_r};
   wire [31:0] rd_val =
      (addr == ADR_CTRL) ? {21'h0, 1'b0, ctrl_r[9:0]} :
      (addr == ADR_TRAV) ? {16'h0000, trav_r} :
      (addr == ADR_CPUL) ? {16'h0000, cpul_r} :
      (addr == ADR_OPUL) ? {16'h0000, opul_r} :
      (addr == ADR_TOUT) ? {16'h0000, tout_r} :
      (addr == ADR_FTRIP) ? {16'h0000, ftl_r} :
      (addr == ADR_STAT) ? {19'h0, stat} :
      (addr == ADR_OFAIL) ? 32'(ofail_r) :
      (addr == ADR_CFAIL) ? 32'(cfail_r) :
      (addr == ADR_CLEAR) ? {31'h0, clear_r} : 32'h0000_0000;

   // ----------------------------------------
   // Time base
   // ----------------------------------------
   // Steps of 0.02 s drive every timer
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pre_r <= '0;
      end else if (ce) begin
         pre_r <= tick ? '0 : pre_r + 32'd1;
      end
   end

   // ----------------------------------------
   // Register file
   // ----------------------------------------
   // Settings writes; read data stands one cycle
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_r <= ctrl_type'(CTRL_RST);
         trav_r <= TRAV_RST;
         cpul_r <= PULSE_RST;
         opul_r <= PULSE_RST;
         tout_r <= TOUT_RST;
         ftl_r <= FTRIP_RST;
         rdata_r <= '0;
      end else if (ce) begin
         if (wr_ctrl) begin
            ctrl_r <= {1'b0, wctrl[9:0]};
         end
         if (wr_en && addr == ADR_TRAV) trav_r <= wdata[15:0];
         if (wr_en && addr == ADR_CPUL) cpul_r <= wdata[15:0];
         if (wr_en && addr == ADR_OPUL) opul_r <= wdata[15:0];
         if (wr_en && addr == ADR_TOUT) tout_r <= wdata[15:0];
         if (wr_en && addr == ADR_FTRIP) ftl_r <= wdata[15:0];
         rdata_r <= rd ? rd_val : '0;
      end
   end

   // Clear action lasts one cycle then returns to idle
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         clear_r <= 1'b0;
         ofail_r <= '0;
         cfail_r <= '0;
      end else if (ce) begin
         clear_r <= wr_clear && wdata[0]; // R02
         ofail_r <= ofail_nxt;            // R23
         cfail_r <= cfail_nxt;            // R23
      end
   end

   // ----------------------------------------
   // Position supervision
   // ----------------------------------------
   // End positions show at once; other breaker positions wait the traverse time
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         trav_cnt_r <= '0;
         brk_r <= POS_INTER;
         cart_r <= POS_INTER;
      end else if (ce) begin
         cart_r <= (kind == KIND_WD) ? raw_cart : POS_INTER; // R20
         if (brk_end) begin
            trav_cnt_r <= '0;
            brk_r <= raw_brk;
         end else begin
            if (trav_cnt_r >= trav_r) begin
               brk_r <= raw_brk; // R11 R12 R20
            end else if (tick) begin
               trav_cnt_r <= trav_cnt_r + 16'd1;
            end
         end
      end
   end

   // ----------------------------------------
   // Control sequencer
   // ----------------------------------------
   // Pulse stops at limit, arrival or timeout; operation waits for arrival or timeout
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st_r <= ST_IDLE;
         open_cmd_r <= 1'b0;
         close_cmd_r <= 1'b0;
         pul_cnt_r <= '0;
         tout_cnt_r <= '0;
         err_r <= 1'b0;
      end else if (ce) begin
         err_r <= expire; // R15
         unique case (st_r)
            ST_IDLE: begin
               pul_cnt_r <= '0;
               tout_cnt_r <= '0;
               if (start_o) begin
                  st_r <= ST_OPEN;
                  open_cmd_r <= 1'b1; // R10
               end else if (start_c) begin
                  st_r <= ST_CLOSE;
                  close_cmd_r <= 1'b1; // R10
               end
            end
            ST_OPEN, ST_CLOSE: begin
               if (tick) begin
                  pul_cnt_r <= pul_cnt_r + 16'd1;
                  tout_cnt_r <= tout_cnt_r + 16'd1;
               end
               if (reached || expire) begin
                  st_r <= ST_IDLE; // R15
               end
               if (reached || pul_end || expire) begin
                  open_cmd_r <= 1'b0;  // R14
                  close_cmd_r <= 1'b0; // R13
               end
            end
         endcase
      end
   end

   // ----------------------------------------
   // Final trip
   // ----------------------------------------
   // Set wins over the end of a running signal
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ft_r <= 1'b0;
         ft_cnt_r <= '0;
      end else if (ce) begin
         if (ft_start) begin
            ft_r <= 1'b1; // R16 R17
            ft_cnt_r <= '0;
         end else if (ft_r && ft_end) begin
            ft_r <= 1'b0;
         end else if (ft_r && tick) begin
            ft_cnt_r <= ft_cnt_r + 16'd1;
         end
      end
   end

   assign rdata = rdata_r;
   assign open_cmd = open_cmd_r;
   assign close_cmd = close_cmd_r;
   assign final_trip = ft_r;
   assign ctrl_error = err_r;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n || !ce);

   sequence s_clr_req;
      wr_clear && wdata[0] ##1 !wr_clear;
   endsequence
   sequence s_bad_held;
      (raw_brk == POS_BAD) && (trav_cnt_r >= trav_r);
   endsequence
   property p_clear_self;
      s_clr_req |=> !clear_r;
   endproperty
   a_clear_self: assert property (p_clear_self) // R02
      else $error("clear action did not return to idle");
   property p_clear_zero;
      clear_r && !fail_o && !fail_c |=> ofail_r == '0 && cfail_r == '0;
   endproperty
   a_clear_zero: assert property (p_clear_zero) // R02
      else $error("counters not zeroed by clear");
   property p_refuse_cnt;
      refuse_c && !clear_r |=> cfail_r == $past(cfail_r) + 1'b1;
   endproperty
   a_refuse_cnt: assert property (p_refuse_cnt) // R23
      else $error("refused close not counted");
   property p_excl;
      !(open_cmd_r && close_cmd_r);
   endproperty
   a_excl: assert property (p_excl) // R10
      else $error("open and close pulses together");
   property p_earth;
      idle && kind == KIND_EARTH |=> !open_cmd_r && !close_cmd_r;
   endproperty
   a_earth: assert property (p_earth) // R05
      else $error("earthing disconnector was commanded");
   property p_sync;
      idle && is_brk && ctrl_r.sync_en && !field_in.sync_ok
         |=> !close_cmd_r;
   endproperty
   a_sync: assert property (p_sync) // R21
      else $error("close without synchrocheck permission");
   property p_ready;
      idle && is_brk && !ready_ok |=> !close_cmd_r;
   endproperty
   a_ready: assert property (p_ready) // R22
      else $error("close without readiness");
   property p_open_cut;
      open_cmd_r && raw_brk == POS_OPEN |=> !open_cmd_r;
   endproperty
   a_open_cut: assert property (p_open_cut) // R14
      else $error("open pulse not cut on arrival");
   property p_close_cut;
      close_cmd_r && raw_brk == POS_CLOSED |=> !close_cmd_r;
   endproperty
   a_close_cut: assert property (p_close_cut) // R13
      else $error("close pulse not cut on arrival");
   property p_bad;
      s_bad_held |=> brk_r == POS_BAD;
   endproperty
   a_bad: assert property (p_bad) // R11
      else $error("bad position not reported");
   property p_tout;
      expire |=> err_r && idle ##1 !err_r;
   endproperty
   a_tout: assert property (p_tout) // R15
      else $error("timeout did not end operation");
   property p_ar;
      trip_done && reclose_expected && !ft_r |=> !ft_r;
   endproperty
   a_ar: assert property (p_ar) // R17
      else $error("final trip while reclosure expected");

endmodule // switchgear_object_control

// *** logic/switchgear_pkg.sv ***
// Constants, types and layouts for the switchgear object control block
// Notes on behaviour
// R01: Separate 32-bit failed open and close counters
// R02: Clear action zeroes counters, then self-returns
// R03: Withdrawable breaker: cart, position, checks, interlocks
// R04: Plain breaker: position, control, checks, interlocks
// R05: Line disconnector controls; earthing one only indicates
// R06: Open input high means open, close closed
// R07: Cart-in high inserted, cart-out high withdrawn
// R08: Apparatus drives ready only when spring charged
// R09: Sync source drives permission only when permitted
// R10: Open and close use separate command pulses
// R11: Both inputs after traverse time report bad
// R12: Neither input after traverse time reports intermediate
// R13: Close pulse bounded, ends early on change
// R14: Open pulse bounded, ends early on change
// R15: Shared timeout raises error, abandons operation
// R16: Final trip pulse length; zero means continuous
// R17: No final trip while reclosure still expected
// R18: Panel control needs configured access level
// R19: Requests from local, remote and application sources
// R20: Same intermediate and bad encoding for cart
// R21: Synchrocheck enabled gates close on permission
// R22: Readiness enabled gates close on polarity
// R23: Refused or timed-out request bumps fail counter
package switchgear_pkg;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 4;
   localparam int STEP_NS = 20_000_000;  // Setting step, 0.02 s
   localparam int STEP_CYCLES = STEP_NS / CLK_PERIOD_NS;
   localparam int TRAV_DEF_MS = 200;
   localparam int PULSE_DEF_MS = 200;
   localparam int TOUT_DEF_MS = 10_000;
   localparam int FTRIP_DEF_MS = 200;
   localparam logic [15:0] TRAV_RST = 16'(TRAV_DEF_MS * 1000 / 20_000);
   localparam logic [15:0] PULSE_RST = 16'(PULSE_DEF_MS * 1000 / 20_000);
   localparam logic [15:0] TOUT_RST = 16'(TOUT_DEF_MS * 1000 / 20_000);
   localparam logic [15:0] FTRIP_RST = 16'(FTRIP_DEF_MS * 1000 / 20_000);

   // ----------------------------------------
   // Register word addresses
   // ----------------------------------------
   localparam logic [3:0] ADR_CTRL = 4'h0;
   localparam logic [3:0] ADR_TRAV = 4'h1;
   localparam logic [3:0] ADR_CPUL = 4'h2;
   localparam logic [3:0] ADR_OPUL = 4'h3;
   localparam logic [3:0] ADR_TOUT = 4'h4;
   localparam logic [3:0] ADR_FTRIP = 4'h5;
   localparam logic [3:0] ADR_STAT = 4'h6;
   localparam logic [3:0] ADR_OFAIL = 4'h7;
   localparam logic [3:0] ADR_CFAIL = 4'h8;
   localparam logic [3:0] ADR_CLEAR = 4'h9;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [1:0] {KIND_WD, KIND_CB, KIND_LINE, KIND_EARTH}
      obj_kind_type;
   // Cart reuses this: open code = withdrawn, closed code = inserted
   typedef enum logic [1:0] {POS_INTER, POS_OPEN, POS_CLOSED, POS_BAD}
      pos_type;
   typedef enum logic [1:0] {RDY_OFF, RDY_HIGH, RDY_LOW, RDY_RSVD}
      rdy_mode_type;
   typedef struct packed {
      logic ft_release;   // Write 1: end a continuous final trip
      logic [1:0] level;  // Panel access level needed
      logic [2:0] src_en; // app, remote, local
      rdy_mode_type rdy;
      logic sync_en;
      obj_kind_type kind;
   } ctrl_type;
   localparam logic [10:0] CTRL_RST = 11'h02E1;
   typedef struct packed {
      logic sync_ok;
      logic ready_ok;
      logic open_allowed;
      logic close_allowed;
      logic busy;
      logic final_trip;
      logic close_cmd;
      logic open_cmd;
      logic cart_used;
      pos_type cart;
      pos_type brk;
   } status_type;
   typedef struct packed {
      logic open_req;
      logic close_req;
   } req_type;
   typedef struct packed {
      logic open_st;
      logic closed_st;
      logic cart_in;
      logic cart_out;
      logic ready;
      logic sync_ok;
   } field_type;

endpackage

// *** sim/breaker_model.sv ***
// Behavioural breaker seen through its status and readiness contacts
`timescale 1ns/10ps
module breaker_model
   import switchgear_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic open_cmd,
   input wire logic close_cmd,
   input wire logic [5:0] travel,
   input wire logic charged,
   input wire logic sync_met,
   output field_type field
);
   // ------------------------------
   // Contact mechanics
   // ------------------------------
   logic closed_r;  // Main contacts closed
   logic [5:0] left_r;  // Travel cycles left, 0 at rest
   // Start a move on a command, flip the contacts when it ends
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         closed_r <= 1'b0;
         left_r <= 6'h00;
      end else if (left_r != 6'h00) begin
         left_r <= left_r - 6'h01;
         closed_r <= (left_r == 6'h01) ? !closed_r : closed_r;
      end else if (closed_r ? open_cmd : close_cmd) begin
         left_r <= travel;
      end
   end
   // Both contacts read low while the mechanism travels
   // Cart stays racked in; readiness and permission come from the bench
   assign field = '{open_st: !closed_r && left_r == 6'h00,
      closed_st: closed_r && left_r == 6'h00, cart_in: 1'b1,
      cart_out: 1'b0, ready: charged, sync_ok: sync_met};
endmodule // breaker_model

// *** sim/switchgear_object_control_test.sv ***
// Self-checking bench for the switchgear object control block
`timescale 1ns/10ps
module switchgear_object_control_test
   import switchgear_pkg::*;
;
   // ------------------------------
   // Stimulus and observed signals
   // ------------------------------
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [31:0] wdata = 32'h0000_0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic ce = 1'b1;  // Clock enable, dropped once to freeze the block
   logic [31:0] rdata;
   req_type src [4] = '{default: 2'h0};  // Local, remote, app, panel
   req_type ilock = 2'h0;
   logic [1:0] plevel = 2'h3;
   logic trip_done = 1'b0;
   logic recl = 1'b0;
   logic ovr = 1'b0;  // Bench drives the status inputs itself
   field_type tfield = 6'h00;
   field_type mfield;
   field_type fin;
   logic [5:0] travel = 6'h03;
   logic charged = 1'b1;
   logic sync_met = 1'b1;
   logic open_cmd;
   logic close_cmd;
   logic final_trip;
   logic ctrl_error;
   int miscompares = 0;
   int total_checks = 0;
   int cyc = 0;
   int n;
   // Refusal table: control word and {interlock, charged, sync, accepted}
   logic [11:0] rf_ctl [6] = '{12'h2E5, 12'h2E9, 12'h2F1, 12'h2E1,
      12'h2E3, 12'h2E2};
   logic [3:0] rf_flg [6] = '{4'h4, 4'h2, 4'h6, 4'hE, 4'h6, 4'hF};
   // Status table: control word, forced inputs, expected status
   logic [11:0] st_ctl [5] = '{12'h2E1, 12'h2E1, 12'h2E0, 12'h2E0,
      12'h2E0};
   logic [5:0] st_fld [5] = '{6'h30, 6'h00, 6'h28, 6'h2C, 6'h20};
   logic [31:0] st_exp [5] = '{32'h0000_0003, 32'h0000_0000,
      32'h0000_0019, 32'h0000_001D, 32'h0000_0011};

   assign fin = ovr ? tfield : mfield;
   always #2 clk = ~clk;

   // Short step of 4 cycles keeps every timer brief
   switchgear_object_control #(.TICK_CYCLES(4)) i_dut (
      .clk(clk), .reset_n(reset_n), .ce(ce), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .field_in(fin),
      .local_req(src[0]), .remote_req(src[1]), .app_req(src[2]),
      .panel_req(src[3]), .panel_level(plevel), .interlock(ilock),
      .trip_done(trip_done), .reclose_expected(recl),
      .open_cmd(open_cmd), .close_cmd(close_cmd),
      .final_trip(final_trip), .ctrl_error(ctrl_error));

   breaker_model i_model (
      .clk(clk), .reset_n(reset_n), .open_cmd(open_cmd),
      .close_cmd(close_cmd), .travel(travel), .charged(charged),
      .sync_met(sync_met), .field(mfield));

   // ------------------------------
   // Bus, request and check tasks
   // ------------------------------
   task automatic conclude();
      $display("checks %0d miscompares %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wreg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   // Read one word and compare the masked bits
   task automatic rchk(input logic [3:0] a, input logic [31:0] exp,
      input logic [31:0] m = 32'hFFFF_FFFF);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      chk(rdata & m, exp);
   endtask

   // One-cycle request on source s
   task req(input int s, input req_type r);
      @(posedge clk);
      src[s] <= r;
      @(posedge clk);
      src[s] <= 2'h0;
   endtask

   task automatic fire(input logic r);
      @(posedge clk);
      recl <= r;
      trip_done <= 1'b1;
      @(posedge clk);
      trip_done <= 1'b0;
   endtask

   function automatic logic pick(input int s);
      return s == 0 ? open_cmd : s == 1 ? close_cmd : final_trip;
   endfunction

   // Wait briefly for an output to rise, then count its high cycles
   task automatic pulse_len(input int s, output int len);
      len = 0;
      for (int i = 0; i < 4; i++) begin
         @(negedge clk);
         if (pick(s) === 1'b1) break;
      end
      while (pick(s) === 1'b1 && len < 99) begin
         len++;
         @(negedge clk);
      end
   endtask

   // Hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         miscompares++;
         conclude();
      end
   end

   // ------------------------------
   // Main sequence
   // ------------------------------
   initial begin
      repeat (16) @(posedge clk);
      reset_n <= 1'b1;
      rchk(ADR_CTRL, 32'h0000_02E1);
      rchk(ADR_TRAV, 32'h0000_000A);
      rchk(ADR_CPUL, 32'h0000_000A);
      rchk(ADR_OPUL, 32'h0000_000A);
      rchk(ADR_TOUT, 32'h0000_01F4);
      rchk(ADR_FTRIP, 32'h0000_000A);
      rchk(ADR_STAT, 32'h0000_0001, 32'h0000_001F);
      wreg(4'hA, 32'hFFFF_FFFF);
      rchk(4'hA, 32'h0000_0000);
      rchk(ADR_OFAIL, 32'h0000_0000);
      // Traverse 2, pulses 3, timeout 8, final trip 2 steps
      wreg(ADR_TRAV, 32'h0000_0002);
      wreg(ADR_CPUL, 32'h0000_0003);
      wreg(ADR_OPUL, 32'h0000_0003);
      wreg(ADR_TOUT, 32'h0000_0008);
      wreg(ADR_FTRIP, 32'h0000_0002);
      req(0, 2'h1);
      pulse_len(1, n);
      chk(32'(n >= 2 && n <= 6), 1);
      rchk(ADR_STAT, 32'h0000_0002, 32'h0000_0003);
      // Slow breaker: open pulse stops at its limit
      travel <= 6'h14;
      req(1, 2'h2);
      pulse_len(0, n);
      chk(32'(n >= 8 && n <= 13), 1);
      repeat (20) @(posedge clk);
      rchk(ADR_STAT, 32'h0000_0001, 32'h0000_0003);
      // Stuck breaker: close pulse capped, then timeout error
      travel <= 6'h3F;
      req(2, 2'h1);
      pulse_len(1, n);
      chk(32'(n >= 8 && n <= 13), 1);
      n = 0;
      for (int i = 0; i < 40 && n == 0; i++) begin
         @(negedge clk);
         n = (ctrl_error === 1'b1) ? 1 : 0;
      end
      chk(n, 1);
      rchk(ADR_CFAIL, 32'h0000_0001);
      repeat (50) @(posedge clk);
      travel <= 6'h03;
      ilock <= 2'h2;
      req(0, 2'h2);
      pulse_len(0, n);
      chk(n, 0);
      rchk(ADR_OFAIL, 32'h0000_0001);
      @(posedge clk);
      ilock <= 2'h0;
      req(0, 2'h2);
      pulse_len(0, n);
      chk(32'(n > 0), 1);
      // Sync, readiness, interlock and type gating of close
      for (int i = 0; i < 6; i++) begin
         wreg(ADR_CTRL, {20'h0_0000, rf_ctl[i]});
         ilock <= {1'b0, rf_flg[i][3]};
         charged <= rf_flg[i][2];
         sync_met <= rf_flg[i][1];
         req(0, 2'h1);
         pulse_len(1, n);
         chk(32'(n > 0), 32'(rf_flg[i][0]));
         repeat (8) @(posedge clk);
      end
      ilock <= 2'h0;
      rchk(ADR_CFAIL, 32'h0000_0006);
      // Breaker and cart status decoding
      @(posedge clk);
      ovr <= 1'b1;
      // Intermediate must wait for the traverse time
      rchk(ADR_STAT, 32'h0000_0002, 32'h0000_0003);
      for (int i = 0; i < 5; i++) begin
         wreg(ADR_CTRL, {20'h0_0000, st_ctl[i]});
         tfield <= st_fld[i];
         repeat (16) @(posedge clk);
         rchk(ADR_STAT, st_exp[i], 32'h0000_001F);
      end
      @(posedge clk);
      ovr <= 1'b0;
      wreg(ADR_CTRL, 32'h0000_02E1);
      // Final trip with and without pending reclosure
      fire(1'b1);
      pulse_len(2, n);
      chk(n, 0);
      fire(1'b0);
      pulse_len(2, n);
      chk(32'(n >= 4 && n <= 9), 1);
      // Clock enable low freezes the final trip timer
      fire(1'b0);
      ce <= 1'b0;
      repeat (20) @(negedge clk);
      chk(32'(final_trip), 1);
      @(posedge clk);
      ce <= 1'b1;
      repeat (12) @(negedge clk);
      chk(32'(final_trip), 0);
      wreg(ADR_FTRIP, 32'h0000_0000);
      fire(1'b0);
      repeat (30) @(negedge clk);
      chk(32'(final_trip), 1);
      wreg(ADR_CTRL, 32'h0000_06E1);
      repeat (2) @(negedge clk);
      chk(32'(final_trip), 0);
      // Statistics clear
      wreg(ADR_CLEAR, 32'h0000_0001);
      repeat (2) @(posedge clk);
      rchk(ADR_OFAIL, 32'h0000_0000);
      rchk(ADR_CFAIL, 32'h0000_0000);
      rchk(ADR_CLEAR, 32'h0000_0000);
      // Local source disabled: its open request is ignored
      wreg(ADR_CTRL, 32'h0000_02C1);
      req(0, 2'h2);
      pulse_len(0, n);
      chk(n, 0);
      wreg(ADR_CTRL, 32'h0000_02E1);
      // Panel access level
      @(posedge clk);
      plevel <= 2'h1;
      req(3, 2'h2);
      pulse_len(0, n);
      chk(n, 0);
      @(posedge clk);
      plevel <= 2'h2;
      req(3, 2'h2);
      pulse_len(0, n);
      chk(32'(n > 0), 1);
      conclude();
   end
endmodule // switchgear_object_control_test
